// ===== hdl/adc_coding_top.sv
// Output coding, mode strap decode and clock shaping of the converter
`default_nettype none
module adc_coding_top
    import adc_pkg::*;
#(
    parameter int REF_SETTLE = REF_SETTLE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sample_clk,
    input wire logic [INPUT_W-1:0] input_pos,
    input wire logic [INPUT_W-1:0] input_neg,
    input wire logic variant_single_pin,
    input wire logic [1:0] mode_level,
    input wire logic format_select,
    input wire logic stab_select,
    input wire logic output_disable_n,
    output logic [DATA_W-1:0] data_out,
    output logic [DATA_W-1:0] data_oe,
    output logic out_of_range_flag,
    output logic out_of_range_oe,
    output logic sha_hold,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq
);
    // ========================================
    // Pin synchronisers
    logic [6:0] pins_s;
    logic sclk_s;
    logic single_s;
    logic [1:0] level_s;
    logic fmt_s;
    logic stab_s;
    logic dis_s;

    sync2 #(.W(7)) u_pins (
        .clk_sys(clk_sys),
        .pin_in({sample_clk, variant_single_pin, mode_level,
                 format_select, stab_select, output_disable_n}),
        .level_out(pins_s)
    );

    assign sclk_s = pins_s[6];
    assign single_s = pins_s[5];
    assign level_s = pins_s[4:3];
    assign fmt_s = pins_s[2];
    assign stab_s = pins_s[1];
    assign dis_s = pins_s[0];

    // ========================================
    // Mode decode
    logic twos_d;
    logic stab_en_d;
    logic twos_q;
    logic stab_en_q;

    always_comb
    begin
        twos_d = fmt_s;
        stab_en_d = stab_s;
        if (single_s)
        begin
            case (mode_level_t'(level_s))
                LVL_OPEN:
                begin
                    twos_d = 1'b0;
                    stab_en_d = 1'b0;
                end
                LVL_SUPPLY:
                begin
                    twos_d = 1'b0;
                    stab_en_d = 1'b1;
                end
                LVL_GROUND:
                begin
                    twos_d = 1'b1;
                    stab_en_d = 1'b1;
                end
                default:
                begin
                    twos_d = 1'b1;
                    stab_en_d = 1'b0;
                end
            endcase
        end
        else
        begin
            twos_d = fmt_s;
            stab_en_d = stab_s;
        end
    end

    // ========================================
    // Sample clock edge, period and stabilizer
    logic sclk_d1_q;
    logic rise;
    logic fall;
    logic [PER_W-1:0] per_cnt_d;
    logic [PER_W-1:0] per_cnt_q;
    logic [PER_W-1:0] period_d;
    logic [PER_W-1:0] period_q;
    logic [7:0] settle_d;
    logic [7:0] settle_q;
    logic hold_d;
    logic hold_q;

    assign rise = sclk_s && !sclk_d1_q;
    assign fall = !sclk_s && sclk_d1_q;

    always_comb
    begin
        per_cnt_d = per_cnt_q;
        period_d = period_q;
        settle_d = settle_q;
        hold_d = hold_q;
        if (per_cnt_q != {PER_W{1'b1}})
        begin
            per_cnt_d = per_cnt_q + 16'h0001;
        end
        if (rise)
        begin
            per_cnt_d = 16'h0001;
            period_d = per_cnt_q;
            if (period_q != per_cnt_q || !stab_en_q)
            begin
                settle_d = 8'h00;
            end
            else if (settle_q != STAB_SETTLE_CNT)
            begin
                settle_d = settle_q + 8'h01;
            end
        end
        if (stab_en_q)
        begin
            // Rise from pin, fall at half period
            if (rise)
            begin
                hold_d = 1'b1;
            end
            else if (per_cnt_q >= {1'b0, period_q[PER_W-1:1]})
            begin
                hold_d = 1'b0;
            end
        end
        else
        begin
            hold_d = sclk_s;
        end
    end

    // ========================================
    // Conversion coding
    logic signed [DIFF_W-1:0] diff;
    logic signed [DIFF_W-1:0] sat;
    logic otr_now;
    logic over_now;
    logic [DATA_W-1:0] code_now;

    always_comb
    begin
        diff = $signed({1'b0, input_pos}) - $signed({1'b0, input_neg});
        // Outside negative or at positive full scale
        otr_now = (diff < NEG_FS) || (diff >= POS_FS);
        over_now = diff >= POS_FS;
        sat = diff;
        if (diff < NEG_FS)
        begin
            sat = NEG_FS;
        end
        else if (diff > POS_TOP)
        begin
            sat = POS_TOP;
        end
        if (twos_q)
        begin
            code_now = sat[DATA_W-1:0];
        end
        else
        begin
            code_now = {~sat[DATA_W-1], sat[DATA_W-2:0]};
        end
    end

    // ========================================
    // Latency pipeline, flag and word together
    localparam int PW = DATA_W + 2;
    logic [PW-1:0] pipe [0:PIPE_LATENCY];

    // Flag rides in the same word
    assign pipe[0] = {over_now, otr_now, code_now};

    // One stage advance per sample edge
    genvar gi;
    generate
        for (gi = 0; gi < PIPE_LATENCY; gi++)
        begin : g_pipe
            pipe_stage #(.W(PW)) u_stage (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .adv(rise),
                .d_in(pipe[gi]),
                .d_out(pipe[gi+1])
            );
        end
    endgenerate

    logic [DATA_W-1:0] data_d;
    logic [DATA_W-1:0] data_q;
    logic otr_d;
    logic otr_q;
    logic oe_d;
    logic oe_q;

    always_comb
    begin
        data_d = data_q;
        otr_d = otr_q;
        // Flag changes only with a new output word
        if (rise)
        begin
            data_d = pipe[PIPE_LATENCY][DATA_W-1:0];
            otr_d = pipe[PIPE_LATENCY][DATA_W];
        end
        // Low disable input drives the data pins
        oe_d = !dis_s;
    end

    // ========================================
    // Reference settle timer
    logic [21:0] ref_cnt_d;
    logic [21:0] ref_cnt_q;
    logic ref_ok;

    // Status only, capture logic does not wait on it
    assign ref_ok = ref_cnt_q >= 22'(REF_SETTLE);

    always_comb
    begin
        ref_cnt_d = ref_cnt_q;
        if (!ref_ok)
        begin
            ref_cnt_d = ref_cnt_q + 22'h000001;
        end
    end

    // ========================================
    // Avalon slave and interrupts
    bus_state_t bus_d;
    bus_state_t bus_q;
    logic wait_d;
    logic wait_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic [IRQ_W-1:0] ist_d;
    logic [IRQ_W-1:0] ist_q;
    logic [IRQ_W-1:0] ien_d;
    logic [IRQ_W-1:0] ien_q;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic take;
    logic irq_d;
    logic irq_q;

    // Over and under split by the piped over bit, not the word sign bit
    assign ev[IRQ_OVER] = rise && pipe[PIPE_LATENCY][DATA_W]
        && pipe[PIPE_LATENCY][DATA_W+1];
    assign ev[IRQ_UNDER] = rise && pipe[PIPE_LATENCY][DATA_W]
        && !pipe[PIPE_LATENCY][DATA_W+1];
    assign take = (bus_q == BUS_ANSWER);

    always_comb
    begin
        bus_d = bus_q;
        wait_d = 1'b1;
        rdata_d = rdata_q;
        ien_d = ien_q;
        clr = '0;
        case (bus_q)
            BUS_IDLE:
            begin
                if (read || write)
                begin
                    bus_d = BUS_ANSWER;
                    wait_d = 1'b0;
                    rdata_d = 32'h00000000;
                    case (address)
                        REG_STATUS:
                        begin
                            rdata_d[ST_TWOS] = twos_q;
                            rdata_d[ST_STAB] = stab_en_q;
                            rdata_d[ST_REF_OK] = ref_ok;
                            rdata_d[ST_STAB_OK] =
                                settle_q == STAB_SETTLE_CNT;
                            rdata_d[ST_OTR] = otr_q;
                        end
                        REG_IRQ_STATUS: rdata_d[IRQ_W-1:0] = ist_q;
                        REG_IRQ_ENABLE: rdata_d[IRQ_W-1:0] = ien_q;
                        default: rdata_d = 32'h00000000;
                    endcase
                end
            end
            BUS_ANSWER:
            begin
                bus_d = BUS_IDLE;
                if (write && address == REG_IRQ_ENABLE)
                begin
                    ien_d = writedata[IRQ_W-1:0];
                end
                if (write && address == REG_IRQ_CLEAR)
                begin
                    clr = writedata[IRQ_W-1:0];
                end
            end
            default: bus_d = BUS_IDLE;
        endcase
        // Set beats clear so no event slips through
        ist_d = (ist_q & ~clr) | ev;
        irq_d = |(ist_d & ien_d);
    end

    // ========================================
    // State registers
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            twos_q <= 1'b0;
            stab_en_q <= 1'b0;
            sclk_d1_q <= 1'b0;
            per_cnt_q <= '0;
            period_q <= '0;
            settle_q <= 8'h00;
            hold_q <= 1'b0;
            data_q <= '0;
            otr_q <= 1'b0;
            oe_q <= 1'b0;
            ref_cnt_q <= 22'h000000;
            bus_q <= BUS_IDLE;
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
            ist_q <= IRQ_RST;
            ien_q <= IRQ_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            twos_q <= twos_d;
            stab_en_q <= stab_en_d;
            sclk_d1_q <= sclk_s;
            per_cnt_q <= per_cnt_d;
            period_q <= period_d;
            settle_q <= settle_d;
            hold_q <= hold_d;
            data_q <= data_d;
            otr_q <= otr_d;
            oe_q <= oe_d;
            ref_cnt_q <= ref_cnt_d;
            bus_q <= bus_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            ist_q <= ist_d;
            ien_q <= ien_d;
            irq_q <= irq_d;
        end
    end

    assign data_out = data_q;
    assign data_oe = {DATA_W{oe_q}};
    assign out_of_range_flag = otr_q;
    assign out_of_range_oe = oe_q;
    assign sha_hold = hold_q;
    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign irq = irq_q;
    // Fall edge only matters to the analog switches, kept for clarity
    logic unused_fall;
    assign unused_fall = fall & take;
endmodule
`default_nettype wire

// ===== shared/adc_pkg.sv
// Constants, encodings and register map of the converter output coder
`default_nettype none
package adc_pkg;
    // ========================================
    // Data path widths and pipeline
    localparam int DATA_W = 12;
    localparam int INPUT_W = 13;
    localparam int DIFF_W = 14;
    localparam int PIPE_LATENCY = 7;
    localparam int PER_W = 16;
    // ========================================
    // Full scale limits in LSB of the difference
    localparam logic signed [DIFF_W-1:0] NEG_FS = 14'sh3800;
    localparam logic signed [DIFF_W-1:0] POS_FS = 14'sh0800;
    localparam logic signed [DIFF_W-1:0] POS_TOP = 14'sh07ff;
    // ========================================
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int REF_SETTLE_MS = 10;
    localparam int REF_SETTLE_CYCLES = REF_SETTLE_MS * 1000 * CLK_MHZ;
    localparam int STAB_SETTLE_EDGES = 100;
    localparam logic [7:0] STAB_SETTLE_CNT = 8'h65;
    // ========================================
    // Single mode pin levels, as seen by the level comparators
    typedef enum logic [1:0] {
        LVL_OPEN = 2'h0,
        LVL_SUPPLY = 2'h1,
        LVL_GROUND = 2'h2,
        LVL_RESISTOR = 2'h3
    } mode_level_t;
    // ========================================
    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1,
        BUS_ANSWER = 2'h2
    } bus_state_t;
    // ========================================
    // Register map, byte addresses
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h4;
    localparam logic [3:0] REG_IRQ_ENABLE = 4'h8;
    localparam logic [3:0] REG_IRQ_CLEAR = 4'hc;
    localparam int ST_TWOS = 0;
    localparam int ST_STAB = 1;
    localparam int ST_REF_OK = 2;
    localparam int ST_STAB_OK = 3;
    localparam int ST_OTR = 4;
    localparam int IRQ_W = 2;
    localparam int IRQ_OVER = 0;
    localparam int IRQ_UNDER = 1;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
endpackage
`default_nettype wire

// ===== hdl/sync2.sv
// Two flip-flop synchroniser for pin levels
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] level_q;

    // No reset: the chain settles within two edges anyway
    always_ff @(posedge clk_sys)
    begin
        meta_q <= pin_in;
        level_q <= meta_q;
    end

    assign level_out = level_q;
endmodule
`default_nettype wire

// ===== hdl/pipe_stage.sv
// One register stage of the output latency pipeline
`default_nettype none
module pipe_stage #(
    parameter int W = 13
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic adv,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] d_out
);
    logic [W-1:0] stage_d;
    logic [W-1:0] stage_q;

    always_comb
    begin
        stage_d = stage_q;
        if (adv)
        begin
            stage_d = d_in;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            stage_q <= '0;
        end
        else
        begin
            stage_q <= stage_d;
        end
    end

    assign d_out = stage_q;
endmodule
`default_nettype wire

// ===== testbench/adc_coding_checker.sv
// Port assertions for the converter output coder
`default_nettype none
module adc_coding_checker
    import adc_pkg::*;
#(
    parameter int REF_SETTLE = 50
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sample_clk,
    input wire logic [INPUT_W-1:0] input_pos,
    input wire logic [INPUT_W-1:0] input_neg,
    input wire logic variant_single_pin,
    input wire logic [1:0] mode_level,
    input wire logic format_select,
    input wire logic stab_select,
    input wire logic output_disable_n,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic [DATA_W-1:0] data_oe,
    input wire logic out_of_range_flag,
    input wire logic out_of_range_oe,
    input wire logic sha_hold,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic irq
);
    logic pin_q;
    logic [3:0] age_q;
    logic [3:0] age_d;
    logic stab_off;
    // ========================================
    // Cycles since the sample pin was seen rising
    always_comb
    begin
        age_d = (age_q == 4'hf) ? age_q : age_q + 4'h1;
        if (sys_rst)
        begin
            age_d = 4'hf;
        end
        else if (sample_clk && !pin_q)
        begin
            age_d = 4'h0;
        end
        // Open and resistor levels both leave the stabilizer off
        stab_off = variant_single_pin ? (mode_level[0] == mode_level[1])
            : !stab_select;
    end
    always_ff @(posedge clk_sys)
    begin
        pin_q <= sample_clk;
        age_q <= age_d;
    end
    // ========================================
    // Assertions
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    oe_release_a:
        assert property (output_disable_n [*5] |-> data_oe == 12'h000)
        else $error("drivers on while disabled");
    oe_drive_a:
        assert property (!output_disable_n [*5] |-> data_oe == 12'hfff)
        else $error("drivers off while enabled");
    oe_pair_a:
        assert property (out_of_range_oe == data_oe[0])
        else $error("flag driver differs");
    flag_code_a:
        assert property (out_of_range_flag |->
            data_out inside {12'h000, 12'hfff, 12'h800, 12'h7ff})
        else $error("flagged word not at a limit");
    flag_step_a:
        assert property ($changed(out_of_range_flag) |->
            age_q inside {[4'h1:4'h4]})
        else $error("flag moved off a sample edge");
    word_step_a:
        assert property ($changed(data_out) |-> age_q inside {[4'h1:4'h4]})
        else $error("word moved off a sample edge");
    hold_level_a:
        // Mode pins reach the hold logic four cycles after the pins move
        assert property ((stab_off && $past(stab_off, 4)
            && $stable(sample_clk)) [*4] |-> sha_hold == sample_clk)
        else $error("hold does not follow clock level");
    hold_rise_a:
        assert property ($stable(stab_off) [*6] ##0 $rose(sha_hold) |->
            age_q inside {[4'h1:4'h4]})
        else $error("hold rose off the sampling edge");
    bus_answer_a:
        assert property ((read || write) && waitrequest |=>
            !waitrequest ##1 waitrequest)
        else $error("bus answer not after one wait cycle");
    over_c: cover property ($rose(out_of_range_flag));
    twos_c: cover property (out_of_range_flag && data_out == 12'h800);
    irq_c: cover property ($rose(irq));
endmodule
bind adc_coding_top adc_coding_checker #(.REF_SETTLE(REF_SETTLE)) chk (
    .clk_sys, .sys_rst, .sample_clk, .input_pos, .input_neg,
    .variant_single_pin, .mode_level, .format_select, .stab_select,
    .output_disable_n, .data_out, .data_oe, .out_of_range_flag,
    .out_of_range_oe, .sha_hold, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .irq
);
`default_nettype wire

// ===== testbench/capture_model.sv
// Capture logic model: sample clock source and word capture
`default_nettype none
module capture_model
    import adc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [DATA_W-1:0] data_pins,
    input wire logic flag_pin,
    output logic sample_clk,
    output logic [DATA_W-1:0] cap_data,
    output logic cap_flag,
    output logic cap_over,
    output logic cap_under,
    output logic [15:0] rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph_q;
    // ========================================
    // Six high, two low: uneven duty exposes the stabilizer
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ph_q <= 3'h0;
            sample_clk <= 1'b0;
            rises <= 16'h0;
        end
        else
        begin
            ph_q <= ph_q + 3'h1;
            sample_clk <= (ph_q >= 3'h2);
            if (ph_q == 3'h2)
            begin
                rises <= rises + 16'h1;
                cap_data <= data_pins;
                cap_flag <= flag_pin;
                // sign bit splits over from under
                cap_over <= flag_pin & data_pins[DATA_W-1];
                cap_under <= flag_pin & ~data_pins[DATA_W-1];
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the converter output coder
`default_nettype none
module testbench
    import adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [4:0] mode;
        logic [INPUT_W-1:0] pos;
        logic [INPUT_W-1:0] neg;
        logic [DATA_W-1:0] word;
        logic flag;
        logic [1:0] st;
    } row_t;
    localparam int LIMIT = 20000;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [INPUT_W-1:0] input_pos = 13'h0, input_neg = 13'h0;
    logic variant_single_pin = 1'b0, format_select = 1'b0;
    logic stab_select = 1'b0, output_disable_n = 1'b0;
    logic [1:0] mode_level = 2'h0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0, write = 1'b0;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic [DATA_W-1:0] data_out, data_oe, data_pins, cap_data;
    logic out_of_range_flag, out_of_range_oe, flag_pin, sample_clk;
    logic sha_hold, waitrequest, irq, cap_flag, cap_over, cap_under;
    logic [15:0] rises;
    int errors = 0, comparisons = 0, cyc = 0, lat = -1, hi;
    row_t r;
    row_t rows [14];
    always #2.5 clk_sys = ~clk_sys;
    // Released lines show a pattern that moves every cycle
    assign data_pins = (data_oe & data_out) | (~data_oe & cyc[DATA_W-1:0]);
    assign flag_pin = out_of_range_oe ? out_of_range_flag : cyc[0];
    adc_coding_top #(.REF_SETTLE(50)) dut (
        .clk_sys, .sys_rst, .sample_clk, .input_pos, .input_neg,
        .variant_single_pin, .mode_level, .format_select, .stab_select,
        .output_disable_n, .data_out, .data_oe, .out_of_range_flag,
        .out_of_range_oe, .sha_hold, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .irq
    );
    capture_model far_end (
        .clk_sys, .sys_rst, .data_pins, .flag_pin, .sample_clk, .cap_data,
        .cap_flag, .cap_over, .cap_under, .rises
    );
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            errors++;
            wrap_up();
        end
    end
    // ========================================
    // Tasks
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] wd);
        @(posedge clk_sys);
        address <= a;
        writedata <= wd;
        read <= !wr;
        write <= wr;
        @(posedge clk_sys);
        while (waitrequest !== 1'b0) @(posedge clk_sys);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic next_rise(input int k);
        logic [15:0] n0;
        repeat (k)
        begin
            n0 = rises;
            @(posedge clk_sys);
            while (rises === n0) @(posedge clk_sys);
        end
    endtask
    task automatic drive(input logic [4:0] m, input logic [12:0] p,
        input logic [12:0] n);
        {variant_single_pin, mode_level, format_select, stab_select} <= m;
        input_pos <= p;
        input_neg <= n;
    endtask
    task automatic hold_high();
        hi = 0;
        repeat (8)
        begin
            @(posedge clk_sys);
            hi += (sha_hold === 1'b1);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ========================================
    // Main sequence
    initial
    begin
        rows = '{'{5'h00, 13'h0, 13'h801, 12'h000, 1'b1, 2'h0},
            '{5'h00, 13'h0, 13'h800, 12'h000, 1'b0, 2'h0},
            '{5'h00, 13'h800, 13'h800, 12'h800, 1'b0, 2'h0},
            '{5'h00, 13'hfff, 13'h800, 12'hfff, 1'b0, 2'h0},
            '{5'h00, 13'hfff, 13'h7ff, 12'hfff, 1'b1, 2'h0},
            '{5'h02, 13'h0, 13'h801, 12'h800, 1'b1, 2'h1},
            '{5'h02, 13'h800, 13'h800, 12'h000, 1'b0, 2'h1},
            '{5'h02, 13'hfff, 13'h7ff, 12'h7ff, 1'b1, 2'h1},
            '{5'h02, 13'hfff, 13'h800, 12'h7ff, 1'b0, 2'h1},
            '{5'h01, 13'h800, 13'h800, 12'h800, 1'b0, 2'h2},
            '{5'h10, 13'h800, 13'h800, 12'h800, 1'b0, 2'h0},
            '{5'h14, 13'h800, 13'h800, 12'h800, 1'b0, 2'h2},
            '{5'h18, 13'h800, 13'h800, 12'h000, 1'b0, 2'h3},
            '{5'h1c, 13'h800, 13'h800, 12'h000, 1'b0, 2'h1}};
        repeat (12) @(posedge clk_sys);
        check("oe in reset", 32'h0, data_oe);
        check("wait in reset", 32'h1, waitrequest);
        sys_rst <= 1'b0;
        bus(1'b0, REG_STATUS, 32'h0);
        check("ref early", 32'h0, rd[ST_REF_OK]);
        $display("test reset done");
        for (int i = 0; i < 14; i++)
        begin
            r = rows[i];
            next_rise(1);
            drive(r.mode, r.pos, r.neg);
            hi = 0;
            while (hi < 16 && (cap_data !== r.word || cap_flag !== r.flag))
            begin
                next_rise(1);
                hi++;
            end
            // A word may match early from the old mode; let pins settle
            next_rise(10);
            check("word", r.word, cap_data);
            check("flag", r.flag, cap_flag);
            if (i > 0 && rows[i-1].mode == r.mode && lat < 0)
                lat = hi;
            else if (i > 0 && rows[i-1].mode == r.mode)
                check("latency", lat, hi);
            bus(1'b0, REG_STATUS, 32'h0);
            check("status", {r.flag, 1'b1, r.st}, {rd[4], rd[2:0]});
        end
        $display("test rows done");
        output_disable_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check("oe off", 32'h0, {data_oe, out_of_range_oe});
        output_disable_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check("oe on", 32'h1fff, {data_oe, out_of_range_oe});
        hold_high();
        check("hold off", 32'h6, hi);
        drive(5'h01, 13'h800, 13'h800);
        next_rise(110);
        hold_high();
        check("hold on", 32'h4, hi);
        bus(1'b0, REG_STATUS, 32'h0);
        check("stab settled", 32'h1, rd[ST_STAB_OK]);
        $display("test clock done");
        bus(1'b0, REG_IRQ_STATUS, 32'h0);
        check("irq rows", 32'h3, rd);
        bus(1'b1, REG_IRQ_CLEAR, 32'h3);
        drive(5'h00, 13'hfff, 13'h7ff);
        next_rise(12);
        check("over seen", 32'h1, cap_over);
        drive(5'h00, 13'h800, 13'h800);
        next_rise(12);
        bus(1'b0, REG_IRQ_STATUS, 32'h0);
        check("irq sticky", 32'h1, rd);
        check("irq masked", 32'h0, irq);
        bus(1'b1, REG_IRQ_ENABLE, 32'h3);
        bus(1'b0, REG_IRQ_ENABLE, 32'h0);
        check("enable", 32'h3, rd);
        check("irq on", 32'h1, irq);
        bus(1'b1, REG_IRQ_CLEAR, 32'h1);
        bus(1'b0, REG_IRQ_STATUS, 32'h0);
        check("irq cleared", 32'h0, rd);
        check("irq off", 32'h0, irq);
        drive(5'h00, 13'h0, 13'h801);
        next_rise(12);
        check("under seen", 32'h1, cap_under);
        bus(1'b0, REG_IRQ_STATUS, 32'h0);
        check("irq under", 32'h2, rd);
        check("irq again", 32'h1, irq);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped", 32'h0, rd);
        $display("test irq done");
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        check("irq reset", 32'h0, irq);
        check("flag reset", 32'h0, out_of_range_flag);
        bus(1'b0, REG_IRQ_ENABLE, 32'h0);
        check("enable reset", 32'h0, rd);
        $display("test mid reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
